// File: hdl/trap_csr_pkg.sv
`default_nettype none
package trap_csr_pkg;
    // =====================================================
    // register addresses
    localparam logic [11:0] ADDR_STATUS = 12'h300;
    localparam logic [11:0] ADDR_ISA = 12'h301;
    localparam logic [11:0] ADDR_LINE_EN = 12'h304;
    localparam logic [11:0] ADDR_TVEC = 12'h305;
    localparam logic [11:0] ADDR_INHIBIT = 12'h320;
    localparam logic [11:0] ADDR_EVT_FIRST = 12'h323;
    localparam logic [11:0] ADDR_EVT_LAST = 12'h33f;
    localparam int EVT_BASE_IDX = 3;
    // =====================================================
    // status word fields
    localparam int ST_GIE = 3;
    localparam int ST_PGIE = 7;
    localparam int ST_UIE = 0;
    localparam int ST_PREV_USER_IRQ_EN = 4;
    localparam int ST_PP_LO = 11;
    localparam logic [1:0] PP_MACHINE = 2'h3;
    localparam logic [31:0] STATUS_RST = 32'h00001800;
    // =====================================================
    // isa word fields
    localparam logic [1:0] ISA_MXL_32 = 2'h1;
    localparam int ISA_X = 23;
    localparam int ISA_M = 12;
    localparam int ISA_I = 8;
    localparam int ISA_F = 5;
    localparam int ISA_C = 2;
    // =====================================================
    // interrupt lines: fast 31:16, ext 11, timer 7, soft 3
    localparam logic [31:0] LINE_EN_MASK = 32'hffff0888;
    localparam logic [31:0] LINE_EN_RST = 32'h00000000;
    // =====================================================
    // trap vector
    localparam int TVEC_BASE_LO = 8;
    localparam logic [5:0] TVEC_MID_RST = 6'h00;
    localparam logic [1:0] TVEC_MODE_RST = 2'h1;
    // =====================================================
    // counter inhibit and event selectors
    localparam logic [31:0] INHIBIT_RST = 32'h0000000d;
    localparam logic [31:0] INHIBIT_FIXED_MASK = 32'h0000000d;
    localparam logic [31:0] EVT_MASK = 32'h0000ffff;
    localparam logic [31:0] EVT_RST = 32'h00000000;
    localparam int NUM_EVT_MAX = 29;
endpackage : trap_csr_pkg
`default_nettype wire

// File: hdl/trap_target.sv
`default_nettype none
// ==========================================================
// handler address: direct base or base plus four times cause
module trap_target (
    input wire logic [31:0] tvec_i,
    input wire logic is_irq_i,
    input wire logic [4:0] cause_i,
    output logic [31:0] target_o
);
    logic [31:0] base_w;
    logic vec_w;
    assign base_w = {tvec_i[31:trap_csr_pkg::TVEC_BASE_LO], 8'h00};
    assign vec_w = tvec_i[0] & is_irq_i;
    // exceptions ignore vectored mode
    assign target_o = vec_w ? (base_w | {25'h0000000, cause_i, 2'h0}) : base_w;
endmodule : trap_target
`default_nettype wire

// File: hdl/machine_trap_control_csrs.sv
`default_nettype none
module machine_trap_control_csrs #(
    parameter int NUM_EVT = 1,
    parameter bit FPU = 1'b0,
    parameter bit CUSTOM_EXT_PARAM = 1'b0,
    parameter bit CLUSTER_PARAM = 1'b0,
    parameter bit FLOAT_IN_INT_REGS_PARAM = 1'b0,
    parameter bit USER_MODE = 1'b0
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [31:0] boot_tvec_i,
    input wire logic csr_we_i,
    input wire logic [11:0] csr_addr_i,
    input wire logic [31:0] csr_wdata_i,
    input wire logic [31:0] irq_i,
    input wire logic exc_i,
    input wire logic mret_i,
    input wire logic uret_i,
    input wire logic [31:0] pc_i,
    output logic [31:0] csr_rdata_o,
    output logic [31:0] status_o,
    output logic [31:0] line_en_o,
    output logic [31:0] pending_o,
    output logic [31:0] inhibit_o,
    output logic [31:0] tvec_o,
    output logic irq_take_o,
    output logic [4:0] irq_cause_o,
    output logic trap_o,
    output logic [31:0] trap_pc_o,
    output logic [31:0] epc_o
);
    // ======================================================
    // storage
    logic gie_q, pgie_q, uie_q, prev_user_irq_en_q;
    logic [31:0] line_en_q;
    logic [23:0] tvec_base_q;
    logic tvec_mode_q;
    logic [31:0] inhibit_q;
    logic [15:0] evt_q [trap_csr_pkg::NUM_EVT_MAX];
    logic [31:0] epc_q;
    logic [31:0] pend_s1_q, pend_q;
    logic [31:0] rdata_q;
    logic trap_q, take_q;
    logic [31:0] trap_pc_q;
    logic [4:0] cause_q;
    logic [1:0] rst_seen_q;

    // ======================================================
    // decode and assembled words
    logic wr_status, wr_line, wr_tvec, wr_inh, evt_hit;
    logic [4:0] evt_idx;
    logic [31:0] status_w, isa_w, tvec_w, inh_mask_w, rdata_d;
    logic [31:0] act_w;
    logic any_act, take_w, trap_w;
    logic [4:0] cause_w;
    logic [31:0] target_w;

    assign wr_status = csr_we_i && (csr_addr_i == trap_csr_pkg::ADDR_STATUS);
    assign wr_line = csr_we_i && (csr_addr_i == trap_csr_pkg::ADDR_LINE_EN);
    assign wr_tvec = csr_we_i && (csr_addr_i == trap_csr_pkg::ADDR_TVEC);
    assign wr_inh = csr_we_i && (csr_addr_i == trap_csr_pkg::ADDR_INHIBIT);
    assign evt_hit = (csr_addr_i >= trap_csr_pkg::ADDR_EVT_FIRST)
                  && (csr_addr_i <= trap_csr_pkg::ADDR_EVT_LAST);
    assign evt_idx = 5'(csr_addr_i - trap_csr_pkg::ADDR_EVT_FIRST);

    // only listed bits exist; the rest read zero
    assign status_w = {19'h00000, trap_csr_pkg::PP_MACHINE, 3'h0, pgie_q, 2'h0,
                       prev_user_irq_en_q, gie_q, 2'h0, uie_q};
    assign isa_w = {trap_csr_pkg::ISA_MXL_32, 6'h00,
                    CUSTOM_EXT_PARAM | CLUSTER_PARAM, 10'h000, 1'b1, 3'h0, 1'b1,
                    2'h0, FPU & ~FLOAT_IN_INT_REGS_PARAM, 2'h0, 1'b1, 2'h0};
    assign tvec_w = {tvec_base_q, 6'h00, 1'b0, tvec_mode_q};

    // inhibit bits only for existing counters
    generate
        for (genvar b = 0; b < 32; b++) begin : g_inh
            if (b < 3) begin : g_fix
                assign inh_mask_w[b] = trap_csr_pkg::INHIBIT_FIXED_MASK[b];
            end else begin : g_evt
                assign inh_mask_w[b] = (b - 3) < NUM_EVT;
            end
        end
    endgenerate

    // ======================================================
    // interrupt selection: highest fast line first, then ext, soft, timer
    assign act_w = pend_q & line_en_q & trap_csr_pkg::LINE_EN_MASK;
    assign any_act = gie_q && (act_w != 32'h0);
    always_comb begin
        cause_w = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (act_w[i] && (i >= 16)) begin
                cause_w = 5'(i);
            end
        end
        if (act_w[31:16] == 16'h0) begin
            if (act_w[11]) begin
                cause_w = 5'd11;
            end else if (act_w[3]) begin
                cause_w = 5'd3;
            end else if (act_w[7]) begin
                cause_w = 5'd7;
            end
        end
    end
    // a new interrupt is not taken while a trap is already being entered
    assign take_w = any_act && !take_q && !exc_i;
    assign trap_w = take_w || exc_i;

    trap_target u_target (
        .tvec_i(tvec_w),
        .is_irq_i(take_w),
        .cause_i(cause_w),
        .target_o(target_w)
    );

    // ======================================================
    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 32'h0;
        case (csr_addr_i)
            trap_csr_pkg::ADDR_STATUS: rdata_d = status_w;
            trap_csr_pkg::ADDR_ISA: rdata_d = isa_w;
            trap_csr_pkg::ADDR_LINE_EN: rdata_d = line_en_q;
            trap_csr_pkg::ADDR_TVEC: rdata_d = tvec_w;
            trap_csr_pkg::ADDR_INHIBIT: rdata_d = inhibit_q & inh_mask_w;
            default: begin
                if (evt_hit && (32'(evt_idx) < NUM_EVT)) begin
                    rdata_d = {16'h0000, evt_q[evt_idx]};
                end
            end
        endcase
    end

    // ======================================================
    // interrupt lines come from outside: two flops first
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pend_s1_q <= 32'h0;
            pend_q <= 32'h0;
        end else begin
            pend_s1_q <= irq_i;
            pend_q <= pend_s1_q;
        end
    end

    // ======================================================
    // status enables: trap stacking beats software writes
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            gie_q <= trap_csr_pkg::STATUS_RST[trap_csr_pkg::ST_GIE];
            pgie_q <= trap_csr_pkg::STATUS_RST[trap_csr_pkg::ST_PGIE];
            uie_q <= 1'b0;
            prev_user_irq_en_q <= 1'b0;
        end else if (trap_w) begin
            pgie_q <= gie_q;
            gie_q <= 1'b0;
            if (USER_MODE) begin
                prev_user_irq_en_q <= uie_q;
            end
        end else if (mret_i) begin
            gie_q <= pgie_q;
        end else if (uret_i && USER_MODE) begin
            uie_q <= prev_user_irq_en_q;
        end else if (wr_status) begin
            gie_q <= csr_wdata_i[trap_csr_pkg::ST_GIE];
        end
    end

    // ======================================================
    // writable configuration words
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            line_en_q <= trap_csr_pkg::LINE_EN_RST;
            tvec_mode_q <= trap_csr_pkg::TVEC_MODE_RST[0];
            inhibit_q <= trap_csr_pkg::INHIBIT_RST;
        end else begin
            if (wr_line) begin
                line_en_q <= csr_wdata_i & trap_csr_pkg::LINE_EN_MASK;
            end
            if (wr_tvec) begin
                tvec_mode_q <= csr_wdata_i[0];
            end
            if (wr_inh) begin
                inhibit_q <= csr_wdata_i & inh_mask_w;
            end
        end
    end

    // boot base is a port, so it is caught by the clock, not the reset value
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            tvec_base_q <= boot_tvec_i[31:trap_csr_pkg::TVEC_BASE_LO];
        end else if (wr_tvec) begin
            tvec_base_q <= csr_wdata_i[31:trap_csr_pkg::TVEC_BASE_LO];
        end
    end

    // ======================================================
    // event selectors, one per implemented counter
    generate
        for (genvar e = 0; e < trap_csr_pkg::NUM_EVT_MAX; e++) begin : g_evt
            if (e < NUM_EVT) begin : g_on
                always_ff @(posedge ref_clk_i) begin
                    if (sys_rst_i) begin
                        evt_q[e] <= trap_csr_pkg::EVT_RST[15:0];
                    end else if (csr_we_i && evt_hit && (evt_idx == 5'(e))) begin
                        evt_q[e] <= csr_wdata_i[15:0];
                    end
                end
            end else begin : g_off
                assign evt_q[e] = 16'h0000;
            end
        end
    endgenerate

    // ======================================================
    // exception pc, trap redirect and registered outputs
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            epc_q <= 32'h0;
            trap_q <= 1'b0;
            take_q <= 1'b0;
            trap_pc_q <= 32'h0;
            cause_q <= 5'h00;
            rdata_q <= 32'h0;
            rst_seen_q <= 2'h0;
        end else begin
            trap_q <= trap_w;
            take_q <= take_w;
            cause_q <= cause_w;
            rdata_q <= rdata_d;
            rst_seen_q <= {rst_seen_q[0], 1'b1};
            if (trap_w) begin
                epc_q <= {pc_i[31:1], 1'b0};
                trap_pc_q <= target_w;
            end else if (mret_i) begin
                trap_pc_q <= epc_q;
            end
        end
    end

    assign csr_rdata_o = rdata_q;
    assign status_o = status_w;
    assign line_en_o = line_en_q;
    assign pending_o = pend_q & trap_csr_pkg::LINE_EN_MASK;
    assign inhibit_o = inhibit_q & inh_mask_w;
    assign tvec_o = tvec_w;
    assign irq_take_o = take_q;
    assign irq_cause_o = cause_q;
    assign trap_o = trap_q;
    assign trap_pc_o = trap_pc_q;
    assign epc_o = epc_q;

    // ======================================================
    // checks
    property p_pgie_save;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        trap_w |=> (pgie_q == $past(gie_q)) && !gie_q;
    endproperty
    a_pgie_save: assert property (p_pgie_save) else $error("prev enable not saved");

    property p_mret;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (mret_i && !trap_w) |=> (gie_q == $past(pgie_q)) && (trap_pc_o == $past(epc_q));
    endproperty
    a_mret: assert property (p_mret) else $error("mret restore wrong");

    property p_status_fixed;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (status_w & 32'hffffff66) == 32'h00001800;
    endproperty
    a_status_fixed: assert property (p_status_fixed) else $error("status fixed bits");

    property p_gie_write;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (wr_status && !trap_w && !mret_i && !uret_i) |=> gie_q == $past(csr_wdata_i[3]);
    endproperty
    a_gie_write: assert property (p_gie_write) else $error("global enable write lost");

    property p_isa;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (csr_addr_i == trap_csr_pkg::ADDR_ISA) |=> (csr_rdata_o & 32'hff7fffdf) == 32'h40001104;
    endproperty
    a_isa: assert property (p_isa) else $error("isa word wrong");

    property p_line_en;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        wr_line |=> line_en_q == ($past(csr_wdata_i) & 32'hffff0888);
    endproperty
    a_line_en: assert property (p_line_en) else $error("line enable write");

    property p_tvec_fixed;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        tvec_o[7:1] == 7'h00;
    endproperty
    a_tvec_fixed: assert property (p_tvec_fixed) else $error("vector low bits");

    property p_tvec_reset;
        @(posedge ref_clk_i)
        (rst_seen_q == 2'h1) |-> (tvec_o[7:0] == 8'h01);
    endproperty
    a_tvec_reset: assert property (p_tvec_reset) else $error("vector reset value");

    property p_inhibit_reset;
        @(posedge ref_clk_i)
        (rst_seen_q == 2'h1) |-> (inhibit_o[3:0] == 4'hd);
    endproperty
    a_inhibit_reset: assert property (p_inhibit_reset) else $error("inhibit reset");

    property p_take_gated;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        irq_take_o |-> $past(gie_q) && ($past(act_w) != 32'h0);
    endproperty
    a_take_gated: assert property (p_take_gated) else $error("irq taken while masked");

    property p_direct;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (exc_i) |=> trap_pc_o == {$past(tvec_base_q), 8'h00};
    endproperty
    a_direct: assert property (p_direct) else $error("exception target");

    property p_pending;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ##2 pending_o == ($past(irq_i, 2) & 32'hffff0888);
    endproperty
    a_pending: assert property (p_pending) else $error("pending mismatch");

    property p_evt_hi;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        evt_hit |=> csr_rdata_o[31:16] == 16'h0000;
    endproperty
    a_evt_hi: assert property (p_evt_hi) else $error("selector upper bits");
endmodule : machine_trap_control_csrs
`default_nettype wire

// File: bench/core_side_model.sv
`default_nettype none
// =====================================================
// core side: trap pulses, pc and interrupt lines
module core_side_model (
    input wire logic clk_i,
    output logic [31:0] irq_o,
    output logic exc_o,
    output logic mret_o,
    output logic uret_o,
    output logic [31:0] pc_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle levels at time zero
    initial begin
        irq_o = 32'h0;
        exc_o = 1'b0;
        mret_o = 1'b0;
        uret_o = 1'b0;
        pc_o = 32'h5a5a_a5a5;
    end

    // pc is only valid with the pulse, so it is scrambled after it
    task automatic pulse_exc(input logic [31:0] pc);
        exc_o = 1'b1;
        pc_o = pc;
        @(posedge clk_i);
        #10;
        exc_o = 1'b0;
        pc_o = ~pc;
    endtask

    // one-cycle return pulse, machine or user
    task automatic pulse_ret(input logic user);
        uret_o = user;
        mret_o = !user;
        @(posedge clk_i);
        #10;
        uret_o = 1'b0;
        mret_o = 1'b0;
        // let an edge pass so a following pulse is a separate request
        @(posedge clk_i);
        #10;
    endtask

    // level lines; wait out the two-flop synchroniser
    task automatic set_irq(input logic [31:0] lines);
        irq_o = lines;
        repeat (4) @(posedge clk_i);
        #10;
    endtask
endmodule // core_side_model
`default_nettype wire

// File: bench/machine_trap_control_csrs_bench.sv
`default_nettype none
module machine_trap_control_csrs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] BOOT = 32'h0001_2345;
    localparam logic [31:0] ISA_EXP = 32'h4080_1124;
    localparam logic [31:0] VBASE = 32'h0000_4a00;
    localparam logic [31:0] DBASE = 32'h0000_7700;
    localparam logic [31:0] PC = 32'h1234_5678;
    logic ref_clk, sys_rst, csr_we, exc, mret, uret, trap, rd_req, rd_cap;
    logic [11:0] csr_addr;
    logic [31:0] csr_wdata, irq, pc, rdata, pending, trap_pc, epc, seed, wd;
    logic [31:0] status, line_en, inhibit, tvec;
    logic take;
    logic [4:0] cause;
    int n_take = 0;
    logic [31:0] rq[$];
    logic [31:0] tq[$];
    int errors = 0;
    int n_tests = 0;
    // =====================================================
    // address, writable mask and reset value of each place
    logic [11:0] t_addr[8] = '{trap_csr_pkg::ADDR_STATUS, trap_csr_pkg::ADDR_ISA,
        trap_csr_pkg::ADDR_LINE_EN, trap_csr_pkg::ADDR_TVEC, trap_csr_pkg::ADDR_INHIBIT,
        trap_csr_pkg::ADDR_EVT_FIRST, 12'h324, 12'h340};
    logic [31:0] t_mask[8] = '{32'h8, 32'h0, 32'hffff_0888, 32'hffff_ff01, 32'hd,
        32'hffff, 32'h0, 32'h0};
    logic [31:0] t_rst[8] = '{32'h1800, ISA_EXP, 32'h0, {BOOT[31:8], 8'h01}, 32'hd,
        32'h0, 32'h0, 32'h0};

    machine_trap_control_csrs #(.FPU(1'b1), .CUSTOM_EXT_PARAM(1'b1)) i_dut (
        .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .boot_tvec_i(BOOT),
        .csr_we_i(csr_we), .csr_addr_i(csr_addr), .csr_wdata_i(csr_wdata),
        .irq_i(irq), .exc_i(exc), .mret_i(mret), .uret_i(uret), .pc_i(pc),
        .csr_rdata_o(rdata), .status_o(status), .line_en_o(line_en), .pending_o(pending),
        .inhibit_o(inhibit), .tvec_o(tvec), .irq_take_o(take), .irq_cause_o(cause),
        .trap_o(trap),
        .trap_pc_o(trap_pc), .epc_o(epc)
    );
    core_side_model i_core (
        .clk_i(ref_clk), .irq_o(irq), .exc_o(exc), .mret_o(mret), .uret_o(uret), .pc_o(pc)
    );

    // clock, 100 ns period
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // tasks start and end just after a rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        csr_we = 1'b1;
        csr_addr = a;
        csr_wdata = d;
        @(posedge ref_clk);
        #10;
        csr_we = 1'b0;
        @(posedge ref_clk);
        #10;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        csr_addr = a;
        rd_req = 1'b1;
        rq.push_back(exp);
        @(posedge ref_clk);
        #10;
        rd_req = 1'b0;
        // an idle edge between requests, so no strobe is set twice at once
        @(posedge ref_clk);
        #10;
    endtask

    task automatic wait_tq();
        for (int k = 0; k < 20 && tq.size() != 0; k++) @(posedge ref_clk);
        #10;
        if (tq.size() != 0) begin
            errors++;
            $display("CHECK FAILED t=%0t trap missing", $time);
        end
    endtask

    // read data lands one cycle after the address; compare mid-cycle
    always @(posedge ref_clk) rd_cap <= rd_req;
    always @(negedge ref_clk) begin
        if (rd_cap === 1'b1) chk(rdata, rq.pop_front());
        if (take === 1'b1) n_take++;
        if (trap === 1'b1 && tq.size() == 0) begin
            errors++;
            $display("CHECK FAILED t=%0t unexpected trap", $time);
        end else if (trap === 1'b1) begin
            chk(trap_pc, tq.pop_front());
        end
    end

    task automatic test_done();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles needed
    initial begin
        #500000;
        errors++;
        $display("CHECK FAILED t=%0t timeout", $time);
        test_done();
    end

    // main sequence
    initial begin
        sys_rst = 1'b1;
        csr_we = 1'b0;
        csr_addr = 12'h0;
        csr_wdata = 32'h0;
        rd_req = 1'b0;
        seed = 32'h297b;
        repeat (3) @(posedge ref_clk);
        #10;
        sys_rst = 1'b0;
        for (int i = 0; i < 8; i++) rd(t_addr[i], t_rst[i]);
        // all ones first, then random words
        for (int n = 0; n < 4; n++) begin
            for (int i = 0; i < 8; i++) begin
                seed = lfsr(seed);
                wd = (n == 0) ? 32'hffff_ffff : seed;
                if (i == 3) wd = wd & 32'hffff_fff9;
                wr(t_addr[i], wd);
                rd(t_addr[i], (wd & t_mask[i]) | (t_rst[i] & ~t_mask[i]));
                if (i == 4) chk(inhibit, wd & 32'hd);
            end
        end
        wr(trap_csr_pkg::ADDR_STATUS, 32'h0);
        wr(trap_csr_pkg::ADDR_TVEC, VBASE | 32'h1);
        wr(trap_csr_pkg::ADDR_LINE_EN, 32'h0001_0880);
        i_core.set_irq(32'h88);
        chk(pending, 32'h88);
        tq.push_back(VBASE + 32'h1c);
        wr(trap_csr_pkg::ADDR_STATUS, 32'h8);
        wait_tq();
        chk({27'h0, cause}, 32'd7);
        rd(trap_csr_pkg::ADDR_STATUS, 32'h1880);
        i_core.set_irq(32'h0);
        i_core.pulse_ret(1'b0);
        rd(trap_csr_pkg::ADDR_STATUS, 32'h1888);
        tq.push_back(VBASE + 32'h40);
        i_core.set_irq(32'h0001_0800);
        wait_tq();
        i_core.set_irq(32'h0);
        i_core.pulse_ret(1'b0);
        tq.push_back(VBASE);
        i_core.pulse_exc(PC);
        wait_tq();
        chk(epc, PC);
        i_core.pulse_ret(1'b0);
        chk(trap_pc, PC);
        wr(trap_csr_pkg::ADDR_TVEC, DBASE);
        tq.push_back(DBASE);
        i_core.set_irq(32'h800);
        wait_tq();
        i_core.set_irq(32'h0);
        i_core.pulse_ret(1'b0);
        i_core.pulse_ret(1'b1);
        rd(trap_csr_pkg::ADDR_STATUS, 32'h1888);
        chk(status, 32'h1888);
        chk(line_en, 32'h0001_0880);
        chk(tvec, DBASE);
        chk(n_take, 32'd3);
        repeat (2) @(posedge ref_clk);
        test_done();
    end
endmodule // machine_trap_control_csrs_bench
`default_nettype wire
